// ==== hw/hpg_gpio.sv ====
// top: host-port pin gpio overlay with register port and pin muxing
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Contract
// - enable bit 12 gives upper address byte pins to gpio, bit 11 lower
// - enable bits 10..7 give data byte lanes 3..0 to gpio
// - bit 6 makes interrupt pin gpio, bit 5 the ready pin
// - bit 3 converts all byte enables, bit 2 the address strobe
// - bit 1 converts both access-type pins to gpio
// - bit 0 converts chip select, data strobes and read/write together
// - data direction bit one means output, effective only while gpio
// - gpio input data bit reads live pin; writes leave pin alone
// - gpio output data bit drives pin and reads back written value
// - control direction bits map byte enables, ready, interrupt, access, strobes
// - gpio input control bit reads pin level; writes ignored at pin
// - gpio output control bit drives pin, reads back, same bit map
// - address direction register sets each of sixteen address pins
module hpg_gpio
   import hpg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [HPG_DATA_W-1:0] host_data_pins_in,
   output logic [HPG_DATA_W-1:0] host_data_pins_out,
   output logic [HPG_DATA_W-1:0] host_data_pins_oe,
   input wire logic [HPG_DATA_W-1:0] port_data_out,
   input wire logic [HPG_DATA_W-1:0] port_data_oe,
   input wire logic [HPG_ADDR_W-1:0] host_address_pins_in,
   output logic [HPG_ADDR_W-1:0] host_address_pins_out,
   output logic [HPG_ADDR_W-1:0] host_address_pins_oe,
   input wire logic [HPG_ADDR_W-1:0] port_addr_out,
   input wire logic [HPG_ADDR_W-1:0] port_addr_oe,
   input wire logic [HPG_CTL_W-1:0] control_pins_in,
   output logic [HPG_CTL_W-1:0] control_pins_out,
   output logic [HPG_CTL_W-1:0] control_pins_oe,
   input wire logic [HPG_CTL_W-1:0] port_ctrl_out,
   input wire logic [HPG_CTL_W-1:0] port_ctrl_oe,
   output logic [HPG_CTL_W-1:0] port_ctrl_gpio
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [31:0] group_enable_reg, group_enable_next;
   logic [31:0] data_dir_reg, data_dir_next;
   logic [31:0] data_val_reg, data_val_next;
   logic [31:0] ctrl_dir_reg, ctrl_dir_next;
   logic [31:0] ctrl_val_reg, ctrl_val_next;
   logic [31:0] addr_dir_reg, addr_dir_next;
   logic [31:0] addr_val_reg, addr_val_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [HPG_DATA_W-1:0] dpin_out_reg, dpin_oe_reg;
   logic [HPG_ADDR_W-1:0] apin_out_reg, apin_oe_reg;
   logic [HPG_CTL_W-1:0] cpin_out_reg, cpin_oe_reg, cgpio_reg;

   // ---------------------------------------------------------------
   // group to pin selects
   // ---------------------------------------------------------------
   function automatic logic [7:0] hpg_lane(input logic en);
      hpg_lane = {8{en}};
   endfunction : hpg_lane

   logic [HPG_DATA_W-1:0] data_sel;
   logic [HPG_ADDR_W-1:0] addr_sel;
   logic [HPG_CTL_W-1:0] ctrl_sel;

   always_comb begin
      data_sel = {hpg_lane(group_enable_reg[HPG_EN_DATA_B3]),
                  hpg_lane(group_enable_reg[HPG_EN_DATA_B3-1]),
                  hpg_lane(group_enable_reg[HPG_EN_DATA_B0+1]),
                  hpg_lane(group_enable_reg[HPG_EN_DATA_B0])};
      addr_sel = {hpg_lane(group_enable_reg[HPG_EN_ADDR_HI]),
                  hpg_lane(group_enable_reg[HPG_EN_ADDR_LO])};
      ctrl_sel = '0;
      ctrl_sel[HPG_CTL_BE0 +: 4] = {4{group_enable_reg[HPG_EN_BYTE_EN]}};
      ctrl_sel[HPG_CTL_ADDR_STB] = group_enable_reg[HPG_EN_ADDR_STB];
      ctrl_sel[HPG_CTL_READY] = group_enable_reg[HPG_EN_READY];
      ctrl_sel[HPG_CTL_INTR] = group_enable_reg[HPG_EN_INTR];
      ctrl_sel[HPG_CTL_ACC0] = group_enable_reg[HPG_EN_ACC_TYPE];
      ctrl_sel[HPG_CTL_ACC1] = group_enable_reg[HPG_EN_ACC_TYPE];
      ctrl_sel[HPG_CTL_RW] = group_enable_reg[HPG_EN_XFER];
      ctrl_sel[HPG_CTL_DS2] = group_enable_reg[HPG_EN_XFER];
      ctrl_sel[HPG_CTL_DS1] = group_enable_reg[HPG_EN_XFER];
      ctrl_sel[HPG_CTL_CS] = group_enable_reg[HPG_EN_XFER];
      // halfword select and the reserved slot stay host-port whatever is written
      ctrl_sel[HPG_CTL_HALFWORD] = 1'b0;
      ctrl_sel[HPG_CTL_RSVD] = 1'b0;
   end

   // ---------------------------------------------------------------
   // pin cells
   // ---------------------------------------------------------------
   logic [HPG_DATA_W-1:0] dpin_out_next, dpin_oe_next, data_rd;
   logic [HPG_ADDR_W-1:0] apin_out_next, apin_oe_next, addr_rd;
   logic [HPG_CTL_W-1:0] cpin_out_next, cpin_oe_next, ctrl_rd;

   hpg_pin_cell #(.WIDTH(HPG_DATA_W)) u_data_cell (
      .gpio_sel(data_sel),
      .gpio_dir(data_dir_reg),
      .gpio_out(data_val_reg),
      .gpio_store(data_val_reg),
      .func_out(port_data_out),
      .func_oe(port_data_oe),
      .pin_in(host_data_pins_in),
      .pin_out_next(dpin_out_next),
      .pin_oe_next(dpin_oe_next),
      .read_val(data_rd)
   );

   hpg_pin_cell #(.WIDTH(HPG_ADDR_W)) u_addr_cell (
      .gpio_sel(addr_sel),
      .gpio_dir(addr_dir_reg[HPG_ADDR_W-1:0]),
      .gpio_out(addr_val_reg[HPG_ADDR_W-1:0]),
      .gpio_store(addr_val_reg[HPG_ADDR_W-1:0]),
      .func_out(port_addr_out),
      .func_oe(port_addr_oe),
      .pin_in(host_address_pins_in),
      .pin_out_next(apin_out_next),
      .pin_oe_next(apin_oe_next),
      .read_val(addr_rd)
   );

   hpg_pin_cell #(.WIDTH(HPG_CTL_W)) u_ctrl_cell (
      .gpio_sel(ctrl_sel),
      .gpio_dir(ctrl_dir_reg[HPG_CTL_W-1:0]),
      .gpio_out(ctrl_val_reg[HPG_CTL_W-1:0]),
      .gpio_store(ctrl_val_reg[HPG_CTL_W-1:0]),
      .func_out(port_ctrl_out),
      .func_oe(port_ctrl_oe),
      .pin_in(control_pins_in),
      .pin_out_next(cpin_out_next),
      .pin_oe_next(cpin_oe_next),
      .read_val(ctrl_rd)
   );

   // ---------------------------------------------------------------
   // register writes and reads
   // ---------------------------------------------------------------
   always_comb begin
      group_enable_next = group_enable_reg;
      data_dir_next = data_dir_reg;
      data_val_next = data_val_reg;
      ctrl_dir_next = ctrl_dir_reg;
      ctrl_val_next = ctrl_val_reg;
      addr_dir_next = addr_dir_reg;
      addr_val_next = addr_val_reg;
      rdata_next = '0;
      if (reg_wr) begin
         case (reg_addr)
            HPG_ADDR_GROUP_EN: group_enable_next = reg_wdata & HPG_EN_MASK;
            HPG_ADDR_DATA_DIR: data_dir_next = reg_wdata;
            // stored even for input pins; the pin only sees it once an output
            HPG_ADDR_DATA_VAL: data_val_next = reg_wdata;
            HPG_ADDR_CTRL_DIR: ctrl_dir_next = reg_wdata & HPG_CTL_MASK;
            HPG_ADDR_CTRL_VAL: ctrl_val_next = reg_wdata & HPG_CTL_MASK;
            HPG_ADDR_ADDR_DIR: addr_dir_next = reg_wdata & HPG_ADDR_MASK;
            HPG_ADDR_ADDR_VAL: addr_val_next = reg_wdata & HPG_ADDR_MASK;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            HPG_ADDR_GROUP_EN: rdata_next = group_enable_reg;
            HPG_ADDR_DATA_DIR: rdata_next = data_dir_reg;
            HPG_ADDR_DATA_VAL: rdata_next = data_rd;
            HPG_ADDR_CTRL_DIR: rdata_next = ctrl_dir_reg;
            HPG_ADDR_CTRL_VAL: rdata_next = {17'h0_0000, ctrl_rd};
            HPG_ADDR_ADDR_DIR: rdata_next = addr_dir_reg;
            HPG_ADDR_ADDR_VAL: rdata_next = {16'h0000, addr_rd};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         group_enable_reg <= HPG_RESET_VAL;
         data_dir_reg <= HPG_RESET_VAL;
         data_val_reg <= HPG_RESET_VAL;
         ctrl_dir_reg <= HPG_RESET_VAL;
         ctrl_val_reg <= HPG_RESET_VAL;
         addr_dir_reg <= HPG_RESET_VAL;
         addr_val_reg <= HPG_RESET_VAL;
         rdata_reg <= HPG_RESET_VAL;
         dpin_out_reg <= '0;
         dpin_oe_reg <= '0;
         apin_out_reg <= '0;
         apin_oe_reg <= '0;
         cpin_out_reg <= '0;
         cpin_oe_reg <= '0;
         cgpio_reg <= '0;
      end else begin
         group_enable_reg <= group_enable_next;
         data_dir_reg <= data_dir_next;
         data_val_reg <= data_val_next;
         ctrl_dir_reg <= ctrl_dir_next;
         ctrl_val_reg <= ctrl_val_next;
         addr_dir_reg <= addr_dir_next;
         addr_val_reg <= addr_val_next;
         rdata_reg <= rdata_next;
         // registered pins add one cycle of latency to the host-port path too
         dpin_out_reg <= dpin_out_next;
         dpin_oe_reg <= dpin_oe_next;
         apin_out_reg <= apin_out_next;
         apin_oe_reg <= apin_oe_next;
         cpin_out_reg <= cpin_out_next;
         cpin_oe_reg <= cpin_oe_next;
         cgpio_reg <= ctrl_sel;
      end
   end

   assign reg_rdata = rdata_reg;
   assign host_data_pins_out = dpin_out_reg;
   assign host_data_pins_oe = dpin_oe_reg;
   assign host_address_pins_out = apin_out_reg;
   assign host_address_pins_oe = apin_oe_reg;
   assign control_pins_out = cpin_out_reg;
   assign control_pins_oe = cpin_oe_reg;
   assign port_ctrl_gpio = cgpio_reg;

endmodule : hpg_gpio

// ==== hw/hpg_pkg.sv ====
// package: register map, field positions and reset values of the host-port gpio overlay
package hpg_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] HPG_ADDR_GROUP_EN = 32'h4300_000c;
   localparam logic [31:0] HPG_ADDR_DATA_DIR = 32'h4300_0010;
   localparam logic [31:0] HPG_ADDR_DATA_VAL = 32'h4300_0014;
   localparam logic [31:0] HPG_ADDR_CTRL_DIR = 32'h4300_0018;
   localparam logic [31:0] HPG_ADDR_CTRL_VAL = 32'h4300_001c;
   localparam logic [31:0] HPG_ADDR_ADDR_DIR = 32'h4300_0020;
   localparam logic [31:0] HPG_ADDR_ADDR_VAL = 32'h4300_0024;

   // ---------------------------------------------------------------
   // group enable bit positions
   // ---------------------------------------------------------------
   localparam int HPG_EN_ADDR_HI = 12;
   localparam int HPG_EN_ADDR_LO = 11;
   localparam int HPG_EN_DATA_B3 = 10;
   localparam int HPG_EN_DATA_B0 = 7;
   localparam int HPG_EN_INTR = 6;
   localparam int HPG_EN_READY = 5;
   localparam int HPG_EN_HALFWORD = 4;
   localparam int HPG_EN_BYTE_EN = 3;
   localparam int HPG_EN_ADDR_STB = 2;
   localparam int HPG_EN_ACC_TYPE = 1;
   localparam int HPG_EN_XFER = 0;

   // writable bits; 4 and 16:13 are kept as storage but steer nothing
   localparam logic [31:0] HPG_EN_MASK = 32'h0001_ffff;

   // ---------------------------------------------------------------
   // control pin bit map (shared by direction and value registers)
   // ---------------------------------------------------------------
   localparam int HPG_CTL_BE0 = 11;
   localparam int HPG_CTL_READY = 10;
   localparam int HPG_CTL_RSVD = 9;
   localparam int HPG_CTL_INTR = 8;
   localparam int HPG_CTL_ACC0 = 7;
   localparam int HPG_CTL_ACC1 = 6;
   localparam int HPG_CTL_HALFWORD = 5;
   localparam int HPG_CTL_RW = 4;
   localparam int HPG_CTL_DS2 = 3;
   localparam int HPG_CTL_DS1 = 2;
   localparam int HPG_CTL_CS = 1;
   localparam int HPG_CTL_ADDR_STB = 0;
   localparam int HPG_CTL_W = 15;
   localparam logic [31:0] HPG_CTL_MASK = 32'h0000_7fff;
   localparam logic [31:0] HPG_ADDR_MASK = 32'h0000_ffff;

   localparam int HPG_DATA_W = 32;
   localparam int HPG_ADDR_W = 16;
   localparam logic [31:0] HPG_RESET_VAL = 32'h0000_0000;

endpackage : hpg_pkg

// ==== hw/hpg_pin_cell.sv ====
// pin cell: selects between host-port function and gpio for a vector of pins
`timescale 1ns/1ps
module hpg_pin_cell
   import hpg_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] gpio_sel,
   input wire logic [WIDTH-1:0] gpio_dir,
   input wire logic [WIDTH-1:0] gpio_out,
   input wire logic [WIDTH-1:0] gpio_store,
   input wire logic [WIDTH-1:0] func_out,
   input wire logic [WIDTH-1:0] func_oe,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out_next,
   output logic [WIDTH-1:0] pin_oe_next,
   output logic [WIDTH-1:0] read_val
);
   always_comb begin
      pin_oe_next = (gpio_sel & gpio_dir) | (~gpio_sel & func_oe);
      pin_out_next = (gpio_sel & gpio_out) | (~gpio_sel & func_out);
      // input gpio reads the live pin, otherwise the stored bit
      read_val = (gpio_sel & ~gpio_dir & pin_in) | (~(gpio_sel & ~gpio_dir) & gpio_store);
   end
endmodule : hpg_pin_cell

// ==== dv/hpg_board.sv ====
// board model: far-side logic on the host-port pins, resolving each wire
`timescale 1ns/1ps
module hpg_board #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic [W-1:0] dut_out,
   input wire logic [W-1:0] dut_oe,
   input wire logic [W-1:0] brd_val,
   input wire logic [W-1:0] brd_en,
   output logic [W-1:0] pin
);
   logic [W-1:0] last_reg = '0;
   // a wire nobody drives flips every cycle, so a stale level never passes as data
   always_ff @(posedge clk) begin
      for (int i = 0; i < W; i++) begin
         // an unknown level counts as low, so a float settles into a known toggle
         last_reg[i] <= (pin[i] === 1'b1);
      end
   end
   always_comb begin
      pin = (dut_oe & dut_out) | (~dut_oe & brd_en & brd_val) | (~dut_oe & ~brd_en & ~last_reg);
   end
endmodule : hpg_board

// ==== dv/hpg_gpio_sva.sv ====
// checker: pin group steering and register port assertions
`timescale 1ns/1ps
module hpg_gpio_sva
   import hpg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [HPG_DATA_W-1:0] host_data_pins_oe,
   input wire logic [HPG_CTL_W-1:0] control_pins_oe,
   input wire logic [HPG_CTL_W-1:0] port_ctrl_oe,
   input wire logic [HPG_CTL_W-1:0] port_ctrl_gpio
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire en_wr = reg_wr && reg_addr == HPG_ADDR_GROUP_EN;

   property p_reset_idle;
      @(posedge mclk) disable iff (1'b0)
      !rst_n |=> host_data_pins_oe == '0 && control_pins_oe == '0 && port_ctrl_gpio == '0;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pins active after reset");
   property p_halfword;
      $past(rst_n) |-> !port_ctrl_gpio[HPG_CTL_HALFWORD] && !port_ctrl_gpio[HPG_CTL_RSVD]
         && control_pins_oe[HPG_CTL_HALFWORD] == $past(port_ctrl_oe[HPG_CTL_HALFWORD]);
   endproperty
   a_halfword: assert property (p_halfword) else $error("halfword pin left host port");
   property p_intr_ready;
      en_wr |-> ##2 port_ctrl_gpio[HPG_CTL_INTR] == $past(reg_wdata[HPG_EN_INTR], 2)
         && port_ctrl_gpio[HPG_CTL_READY] == $past(reg_wdata[HPG_EN_READY], 2);
   endproperty
   a_intr_ready: assert property (p_intr_ready) else $error("interrupt or ready steering");
   property p_be_strobe;
      en_wr |-> ##2 port_ctrl_gpio[14:11] == {4{$past(reg_wdata[HPG_EN_BYTE_EN], 2)}}
         && port_ctrl_gpio[HPG_CTL_ADDR_STB] == $past(reg_wdata[HPG_EN_ADDR_STB], 2);
   endproperty
   a_be_strobe: assert property (p_be_strobe) else $error("byte enable or strobe steering");
   property p_acc_type;
      en_wr |-> ##2 port_ctrl_gpio[7:6] == {2{$past(reg_wdata[HPG_EN_ACC_TYPE], 2)}};
   endproperty
   a_acc_type: assert property (p_acc_type) else $error("access type steering");
   property p_xfer;
      en_wr |-> ##2 port_ctrl_gpio[4:1] == {4{$past(reg_wdata[HPG_EN_XFER], 2)}};
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer pin group steering");
   property p_host_kept;
      $past(rst_n) && !$past(port_ctrl_gpio[HPG_CTL_CS]) && !port_ctrl_gpio[HPG_CTL_CS]
         |-> control_pins_oe[HPG_CTL_CS] == $past(port_ctrl_oe[HPG_CTL_CS]);
   endproperty
   a_host_kept: assert property (p_host_kept) else $error("host pin not following port");
   property p_ctl_rsvd;
      reg_rd && (reg_addr == HPG_ADDR_CTRL_DIR || reg_addr == HPG_ADDR_CTRL_VAL)
         |=> reg_rdata[31:15] == '0;
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved control bits not zero");
endmodule : hpg_gpio_sva

bind hpg_gpio hpg_gpio_sva i_sva (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .host_data_pins_oe(host_data_pins_oe), .control_pins_oe(control_pins_oe),
   .port_ctrl_oe(port_ctrl_oe), .port_ctrl_gpio(port_ctrl_gpio));

// ==== dv/tb_hpg_gpio.sv ====
// testbench: register port, pin steering and board side of the gpio overlay
`timescale 1ns/1ps
module tb_hpg_gpio
   import hpg_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rv;
   logic [31:0] d_in, d_out, d_oe, pd_out = '0, pd_oe = '0, bd_val = '0, bd_en = '0;
   logic [15:0] a_in, a_out, a_oe, pa_out = '0, pa_oe = '0, ba_val = '0, ba_en = '0;
   logic [14:0] c_in, c_out, c_oe, c_gpio, pc_out = '0, pc_oe = '0, bc_val = '0, bc_en = '0;
   int failures = 0;
   int cmp_count = 0;

   always #2.5 mclk = ~mclk;

   hpg_gpio i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_data_pins_in(d_in),
      .host_data_pins_out(d_out), .host_data_pins_oe(d_oe), .port_data_out(pd_out),
      .port_data_oe(pd_oe), .host_address_pins_in(a_in), .host_address_pins_out(a_out),
      .host_address_pins_oe(a_oe), .port_addr_out(pa_out), .port_addr_oe(pa_oe),
      .control_pins_in(c_in), .control_pins_out(c_out), .control_pins_oe(c_oe),
      .port_ctrl_out(pc_out), .port_ctrl_oe(pc_oe), .port_ctrl_gpio(c_gpio));
   hpg_board #(.W(32)) i_bd (.clk(mclk), .dut_out(d_out), .dut_oe(d_oe), .brd_val(bd_val),
      .brd_en(bd_en), .pin(d_in));
   hpg_board #(.W(16)) i_ba (.clk(mclk), .dut_out(a_out), .dut_oe(a_oe), .brd_val(ba_val),
      .brd_en(ba_en), .pin(a_in));
   hpg_board #(.W(15)) i_bc (.clk(mclk), .dut_out(c_out), .dut_oe(c_oe), .brd_val(bc_val),
      .brd_en(bc_en), .pin(c_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      // hand back on an edge so the caller's next drive lands on it
      @(posedge mclk);
   endtask : rd

   // pins are registered: the edge after a write carries its effect
   task automatic settle();
      @(posedge mclk);
      #1;
   endtask : settle

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic t_reset_vals();
      for (int i = 0; i < 7; i++) begin
         rd(HPG_ADDR_GROUP_EN + 32'(4 * i), rv);
         chk(rv, HPG_RESET_VAL, "reset value");
      end
      settle();
      chk(d_oe | 32'(a_oe) | 32'(c_oe), '0, "pin enables idle");
      wr(32'h4300_0028, 32'hFFFF_FFFF);
      rd(32'h4300_0028, rv);
      chk(rv, '0, "unmapped read");
   endtask : t_reset_vals

   task automatic t_groups();
      logic [31:0] ed, ea, ec;
      wr(HPG_ADDR_DATA_DIR, 32'hFFFF_FFFF);
      wr(HPG_ADDR_ADDR_DIR, 32'h0000_FFFF);
      wr(HPG_ADDR_CTRL_DIR, 32'h0000_7DFF);
      // bit 4 is skipped: software keeps it zero
      for (int b = 0; b < 13; b++) begin
         ed = (b >= 7 && b <= 10) ? 32'h0000_00FF << (8 * (b - 7)) : '0;
         ea = (b >= 11) ? 32'h0000_00FF << (8 * (b - 11)) : '0;
         case (b)
            0: ec = 32'h0000_001E;
            1: ec = 32'h0000_00C0;
            2: ec = 32'h0000_0001;
            3: ec = 32'h0000_7800;
            5: ec = 32'h0000_0400;
            6: ec = 32'h0000_0100;
            default: ec = '0;
         endcase
         if (b != HPG_EN_HALFWORD) begin
            wr(HPG_ADDR_GROUP_EN, 32'h0000_0001 << b);
            settle();
            chk(d_oe, ed, "data lane oe");
            chk(32'(a_oe), ea, "address oe");
            chk(32'(c_oe), ec, "control oe");
            chk(32'(c_gpio), ec, "control gpio flag");
         end
      end
   endtask : t_groups

   task automatic t_ctrl();
      wr(HPG_ADDR_GROUP_EN, 32'h0000_006F);
      wr(HPG_ADDR_CTRL_VAL, 32'hFFFF_55AA);
      settle();
      chk(32'(c_out) & 32'h0000_7DDF, 32'h0000_55AA & 32'h0000_7DDF, "control out");
      rd(HPG_ADDR_CTRL_VAL, rv);
      chk(rv, 32'h0000_55AA, "control readback");
      wr(HPG_ADDR_CTRL_DIR, 32'h0000_0000);
      bc_en <= 15'h7DDF;
      bc_val <= 15'h1234;
      wr(HPG_ADDR_CTRL_VAL, 32'h0000_0000);
      settle();
      chk(32'(c_oe), '0, "control input not driven");
      rd(HPG_ADDR_CTRL_VAL, rv);
      chk(rv, 32'h0000_1234 & 32'h0000_7DDF, "control input level");
      bc_en <= '0;
   endtask : t_ctrl

   task automatic t_data();
      wr(HPG_ADDR_GROUP_EN, 32'h0000_0000);
      pd_oe <= 32'hFFFF_0000;
      pd_out <= 32'h1234_5678;
      pc_oe <= 15'h7FFF;
      pc_out <= 15'h2A5A;
      wr(HPG_ADDR_DATA_DIR, 32'h0F0F_0F0F);
      wr(HPG_ADDR_DATA_VAL, 32'hFFFF_FFFF);
      settle();
      chk(d_oe, pd_oe, "host data oe kept");
      chk(d_out & pd_oe, pd_out & pd_oe, "host data out kept");
      chk(32'(c_oe), 32'h0000_7FFF, "host control oe kept");
      chk(32'(c_out), 32'h0000_2A5A, "host control out kept");
      @(posedge mclk);
      bd_en <= 32'hF0F0_F0F0;
      bd_val <= 32'hA5A5_A5A5;
      wr(HPG_ADDR_GROUP_EN, 32'h0000_0780);
      settle();
      chk(d_oe, 32'h0F0F_0F0F, "gpio data oe");
      chk(d_out & 32'h0F0F_0F0F, 32'h0F0F_0F0F, "gpio data out");
      rd(HPG_ADDR_DATA_VAL, rv);
      chk(rv, 32'h0F0F_0F0F | (32'hA5A5_A5A5 & 32'hF0F0_F0F0), "data read");
      bd_val <= 32'h5A5A_5A5A;
      rd(HPG_ADDR_DATA_VAL, rv);
      chk(rv, 32'h0F0F_0F0F | (32'h5A5A_5A5A & 32'hF0F0_F0F0), "live data read");
      bd_en <= '0;
      pd_oe <= '0;
      pc_oe <= '0;
   endtask : t_data

   task automatic t_addr();
      pa_oe <= 16'hFFFF;
      pa_out <= 16'h3C96;
      wr(HPG_ADDR_ADDR_DIR, 32'h0000_00FF);
      wr(HPG_ADDR_ADDR_VAL, 32'h0000_A5C3);
      settle();
      chk(32'(a_oe), 32'h0000_FFFF, "host address oe kept");
      chk(32'(a_out), 32'h0000_3C96, "host address out kept");
      @(posedge mclk);
      ba_en <= 16'hFF00;
      ba_val <= 16'h5A00;
      wr(HPG_ADDR_GROUP_EN, 32'h0000_1800);
      settle();
      chk(32'(a_oe), 32'h0000_00FF, "gpio address oe");
      chk(32'(a_out) & 32'h0000_00FF, 32'h0000_00C3, "gpio address out");
      rd(HPG_ADDR_ADDR_VAL, rv);
      chk(rv, 32'h0000_5AC3, "address read");
      pa_oe <= '0;
      ba_en <= '0;
   endtask : t_addr

   task automatic finish_test();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      #20000;
      failures++;
      $display("CHECK FAILED at %0t: run did not end in time", $time);
      finish_test();
   end

   initial begin
      do_reset();
      t_reset_vals();
      t_groups();
      t_ctrl();
      t_data();
      t_addr();
      do_reset();
      t_reset_vals();
      finish_test();
   end
endmodule : tb_hpg_gpio
